// ---- core/usb_ep_config.sv ----
/*
 * endpoint enable and reset, per-endpoint configuration, status view and
 * frame number tracking for a high-speed usb device controller.
 * assumes a FIFO engine that supplies status fields and honours epActive
 * and epFifoReset, and a packet decoder that gives frame strobes.
 */
`timescale 1ns/1ns
module usb_ep_config
    import usb_ep_pkg::*;
#(
    parameter int NUM_EP = 8,
    parameter logic [NUM_EP-1:0] HB_ISO_CAPABLE = {NUM_EP{1'b1}},
    parameter logic [2*NUM_EP-1:0] EP_MAX_BANKS = {NUM_EP{2'h2}},
    parameter logic [3*NUM_EP-1:0] EP_MAX_SIZE = {NUM_EP{3'h6}},
    parameter logic [19:0] FIFO_BYTES = 20'h01000
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // usb bus events
    input wire logic busReset,
    input wire logic sofStrobe,
    input wire logic msofStrobe,
    input wire logic [10:0] frameIn,
    input wire logic [2:0] microIn,
    input wire logic pidCrcBad,
    output logic sofEvent,
    output logic msofEvent,
    // endpoint control towards the FIFO engine
    output logic [NUM_EP-1:0] epActive,
    output logic [NUM_EP-1:0] epFifoReset,
    output logic [2*NUM_EP-1:0] epTransferType,
    output logic [NUM_EP-1:0] epDirIn,
    output logic [NUM_EP-1:0] epAutoSwitch,
    output logic [2*NUM_EP-1:0] epBankCount,
    output logic [3*NUM_EP-1:0] epBankSize,
    output logic [NUM_EP-1:0] epMemReserve,
    output logic [2*NUM_EP-1:0] epTransactions,
    output logic [NUM_EP-1:0] epConfigValid,
    output logic [2*NUM_EP-1:0] epToggle,
    // status from the FIFO engine
    input wire logic [11*NUM_EP-1:0] fifoByteCount,
    input wire logic [NUM_EP-1:0] fifoCtrlDir,
    input wire logic [NUM_EP-1:0] fifoRwAll,
    input wire logic [2*NUM_EP-1:0] fifoCurBank,
    input wire logic [2*NUM_EP-1:0] fifoBusyBanks,
    input wire logic [NUM_EP-1:0] fifoTransErr,
    input wire logic [8*NUM_EP-1:0] fifoEvents,
    input wire logic [NUM_EP-1:0] toggleLoad,
    input wire logic [2*NUM_EP-1:0] toggleIn,
    input wire logic [NUM_EP-1:0] toggleResetReq
);
    localparam logic [11:0] SPAN = 12'(4 * NUM_EP);

    generate
        if (NUM_EP < 1 || NUM_EP > MAX_EP) begin : g_bad_count
            $error("endpoint count must be 1 to 8");
        end
        if (FIFO_BYTES == 20'h00000) begin : g_bad_fifo
            $error("fifo size must be nonzero");
        end
    endgenerate

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic slotHit(input logic [11:0] addr, input logic [11:0] base);
        logic [11:0] ofs;
        ofs = addr - base;
        slotHit = (addr >= base) && (ofs < SPAN) && (ofs[1:0] == 2'h0);
    endfunction : slotHit

    function automatic logic [2:0] slotIndex(input logic [11:0] addr, input logic [11:0] base);
        logic [11:0] ofs;
        ofs = addr - base;
        slotIndex = ofs[4:2];
    endfunction : slotIndex

    function automatic logic [15:0] bankBytes(input logic [2:0] size, input logic [1:0] banks);
        bankBytes = (BASE_BANK_BYTES << size) * (16'({14'h0000, banks}) + 16'h0001);
    endfunction : bankBytes

    logic cfgHit, statusHit;
    logic [2:0] cfgIdx, statusIdx;
    logic cfgWrite;

    assign cfgHit = slotHit(regAddr, CONFIG_BASE);
    assign cfgIdx = slotIndex(regAddr, CONFIG_BASE);
    assign statusHit = slotHit(regAddr, STATUS_BASE);
    assign statusIdx = slotIndex(regAddr, STATUS_BASE);
    assign cfgWrite = regWrite && cfgHit;

    // ************************************************************
    // enable and soft reset register
    // ************************************************************
    logic [NUM_EP-1:0] epEnable, next_epEnable;
    logic [NUM_EP-1:0] epSoftReset, next_epSoftReset;
    logic [NUM_EP-1:0] epHeld;

    always_comb begin
        next_epEnable = epEnable;
        next_epSoftReset = epSoftReset;
        if (regWrite && regAddr == ENABLE_RESET_OFS) begin
            next_epEnable = regWdata[ENABLE_LSB +: NUM_EP];
            next_epSoftReset = regWdata[SOFT_RESET_LSB +: NUM_EP];
        end
        if (busReset) begin
            next_epSoftReset = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            epEnable <= '0;
            epSoftReset <= '0;
        end else begin
            epEnable <= next_epEnable;
            epSoftReset <= next_epSoftReset;
        end
    end

    assign epHeld = epSoftReset | ~epEnable;
    assign epFifoReset = epHeld;
    assign epActive = epEnable;

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [1:0] xferType [NUM_EP];
    logic [1:0] next_xferType [NUM_EP];
    logic dirIn [NUM_EP];
    logic next_dirIn [NUM_EP];
    logic auto_bank_switch [NUM_EP];
    logic next_auto_bank_switch [NUM_EP];
    logic [1:0] banks [NUM_EP];
    logic [1:0] next_banks [NUM_EP];
    logic [2:0] bankSize [NUM_EP];
    logic [2:0] next_bankSize [NUM_EP];
    logic memReserve [NUM_EP];
    logic next_memReserve [NUM_EP];
    logic [1:0] trans [NUM_EP];
    logic [1:0] next_trans [NUM_EP];
    logic config_valid [NUM_EP];
    logic next_config_valid [NUM_EP];
    logic fits;

    always_comb begin
        logic [19:0] used;
        logic [1:0] wBanks;
        logic [2:0] wSize;
        used = 20'h00000;
        wBanks = regWdata[CFG_BANKS_LSB +: 2];
        wSize = regWdata[CFG_SIZE_LSB +: 3];
        for (int j = 0; j < NUM_EP; j++) begin
            if (memReserve[j] && 3'(j) != cfgIdx) begin
                used = used + {4'h0, bankBytes(bankSize[j], banks[j])};
            end
        end
        // banks and size within limits and memory
        fits = (wBanks != BANKS_RESERVED) && (wSize != SIZE_UNDEFINED)
            && (wBanks <= EP_MAX_BANKS[2*cfgIdx +: 2])
            && (wSize <= EP_MAX_SIZE[3*cfgIdx +: 3])
            && (used + {4'h0, bankBytes(wSize, wBanks)} <= FIFO_BYTES);
    end

    always_comb begin
        for (int i = 0; i < NUM_EP; i++) begin
            next_xferType[i] = xferType[i];
            next_dirIn[i] = dirIn[i];
            next_auto_bank_switch[i] = auto_bank_switch[i];
            next_banks[i] = banks[i];
            next_bankSize[i] = bankSize[i];
            next_memReserve[i] = memReserve[i];
            next_trans[i] = trans[i];
            next_config_valid[i] = config_valid[i];
            if (cfgWrite && cfgIdx == 3'(i)) begin
                next_xferType[i] = regWdata[CFG_TYPE_LSB +: 2];
                next_dirIn[i] = regWdata[CFG_DIR];
                next_auto_bank_switch[i] = regWdata[CFG_AUTO_BANK_SWITCH];
                next_banks[i] = regWdata[CFG_BANKS_LSB +: 2];
                next_bankSize[i] = regWdata[CFG_SIZE_LSB +: 3];
                next_memReserve[i] = regWdata[CFG_RESERVE];
                next_config_valid[i] = regWdata[CFG_RESERVE] && fits;
                if (HB_ISO_CAPABLE[i]) begin
                    next_trans[i] = regWdata[CFG_TRANS_LSB +: 2];
                end
            end
            if (epHeld[i]) begin
                next_auto_bank_switch[i] = 1'b0;
                next_trans[i] = TRANS_RESET;
            end
            if (busReset) begin
                next_xferType[i] = XFER_CONTROL;
                next_auto_bank_switch[i] = 1'b0;
                next_dirIn[i] = 1'b0;
                if (i != 0) begin
                    next_banks[i] = 2'h0;
                    next_bankSize[i] = 3'h0;
                    next_memReserve[i] = 1'b0;
                    next_config_valid[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_EP; i++) begin
            if (!rst_b) begin
                xferType[i] <= XFER_CONTROL;
                dirIn[i] <= 1'b0;
                auto_bank_switch[i] <= 1'b0;
                banks[i] <= 2'h0;
                bankSize[i] <= 3'h0;
                memReserve[i] <= 1'b0;
                trans[i] <= TRANS_RESET;
                config_valid[i] <= 1'b0;
            end else begin
                xferType[i] <= next_xferType[i];
                dirIn[i] <= next_dirIn[i];
                auto_bank_switch[i] <= next_auto_bank_switch[i];
                banks[i] <= next_banks[i];
                bankSize[i] <= next_bankSize[i];
                memReserve[i] <= next_memReserve[i];
                trans[i] <= next_trans[i];
                config_valid[i] <= next_config_valid[i];
            end
        end
    end

    // ************************************************************
    // data toggle
    // ************************************************************
    logic [1:0] toggle [NUM_EP];
    logic [1:0] next_toggle [NUM_EP];

    always_comb begin
        for (int i = 0; i < NUM_EP; i++) begin
            next_toggle[i] = toggle[i];
            if (toggleLoad[i] && !epHeld[i]) begin
                next_toggle[i] = toggleIn[2*i +: 2];
            end
            if (toggleResetReq[i] || !epEnable[i]) begin
                next_toggle[i] = TOGGLE_DEFAULT;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_EP; i++) begin
            if (!rst_b) begin
                toggle[i] <= TOGGLE_DEFAULT;
            end else begin
                toggle[i] <= next_toggle[i];
            end
        end
    end

    // ************************************************************
    // flattened outputs
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_out
            assign epTransferType[2*g +: 2] = xferType[g];
            assign epDirIn[g] = dirIn[g] && (xferType[g] != XFER_CONTROL);
            assign epAutoSwitch[g] = auto_bank_switch[g];
            assign epBankCount[2*g +: 2] = banks[g];
            assign epBankSize[3*g +: 3] = bankSize[g];
            assign epMemReserve[g] = memReserve[g];
            assign epTransactions[2*g +: 2] = trans[g];
            assign epConfigValid[g] = config_valid[g];
            assign epToggle[2*g +: 2] = toggle[g];
        end
    endgenerate

    // ************************************************************
    // frame tracker
    // ************************************************************
    logic [31:0] frameWord;

    usb_frame_tracker u_frame (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .busReset(busReset),
        .sofStrobe(sofStrobe),
        .msofStrobe(msofStrobe),
        .frameIn(frameIn),
        .microIn(microIn),
        .pidCrcBad(pidCrcBad),
        .frameWord(frameWord),
        .sofEvent(sofEvent),
        .msofEvent(msofEvent)
    );

    // ************************************************************
    // read data
    // ************************************************************
    logic [31:0] next_regRdata;

    always_comb begin
        logic [31:0] cfgWord;
        logic [31:0] stWord;
        int s;
        s = int'(statusIdx);
        cfgWord = CONFIG_RESET;
        stWord = STATUS_RESET;
        next_regRdata = 32'h00000000;
        if (int'(cfgIdx) < NUM_EP) begin
            cfgWord[CFG_TYPE_LSB +: 2] = xferType[cfgIdx];
            cfgWord[CFG_DIR] = dirIn[cfgIdx];
            cfgWord[CFG_AUTO_BANK_SWITCH] = auto_bank_switch[cfgIdx];
            cfgWord[CFG_BANKS_LSB +: 2] = banks[cfgIdx];
            cfgWord[CFG_SIZE_LSB +: 3] = bankSize[cfgIdx];
            cfgWord[CFG_RESERVE] = memReserve[cfgIdx];
            cfgWord[CFG_TRANS_LSB +: 2] = trans[cfgIdx];
        end
        if (s < NUM_EP) begin
            stWord[ST_CONFIG_VALID] = config_valid[s];
            stWord[ST_TOGGLE_LSB +: 2] = toggle[s];
            // FIFO fields read reset while held
            if (!epHeld[s]) begin
                stWord[ST_COUNT_LSB +: 11] = fifoByteCount[11*s +: 11];
                stWord[ST_CONTROL_DIRECTION] = fifoCtrlDir[s];
                stWord[ST_ACCESS_PERMITTED] = fifoRwAll[s];
                stWord[ST_BANK_LSB +: 2] = fifoCurBank[2*s +: 2];
                stWord[ST_BUSY_LSB +: 2] = fifoBusyBanks[2*s +: 2];
                stWord[ST_ERR] = fifoTransErr[s];
                stWord[7:0] = fifoEvents[8*s +: 8];
            end
        end
        if (regRead) begin
            if (regAddr == ENABLE_RESET_OFS) begin
                next_regRdata[ENABLE_LSB +: NUM_EP] = epEnable;
                next_regRdata[SOFT_RESET_LSB +: NUM_EP] = epSoftReset;
            end else if (regAddr == FRAME_NUMBER_OFS) begin
                next_regRdata = frameWord;
            end else if (cfgHit) begin
                next_regRdata = cfgWord;
            end else if (statusHit) begin
                next_regRdata = stWord;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            regRdata <= 32'h00000000;
        end else begin
            regRdata <= next_regRdata;
        end
    end
endmodule : usb_ep_config

// ---- core/usb_ep_pkg.sv ----
/*
 * constants for the endpoint management block: register offsets, field positions,
 * reset values and the transfer type enumeration.
 * assumes a 12-bit byte address on the register port and 32-bit register words.
 */
//
// Summary of operation
// - endpoint reset holds FIFO and its registers, keeping reserve, banks, size, direction, type.
// - endpoint reset clears FIFO state but keeps toggle; toggle reset request restores it.
// - endpoint under reset stays enabled with its configuration active.
// - software ends endpoint reset by writing zero; bus reset also clears it.
// - disabled endpoint is inactive, ignores requests, registers reset, configuration kept.
// - frame CRC error flag updates with every frame and micro-frame strobe; bus reset clears it.
// - 11-bit frame number captured from every frame start, even corrupted; bus reset clears.
// - 3-bit micro-frame number captured, cleared at full frame start and bus reset.
// - transactions code 01, 10, 11 means one, two, three; 00 for incapable endpoints.
// - transactions field writable only on high-bandwidth capable endpoints, else reads zero.
// - type field decodes control, isochronous, bulk, interrupt; bus reset clears it.
// - automatic bank switch bit enables switching; bus reset clears it.
// - direction one means IN, zero OUT; IN invalid on control; bus reset clears.
// - bank size code doubles per step from 8 to 512 bytes; 111 undefined.
// - bank count code gives one, two or three banks; 11 reserved.
// - writing reserve one reserves FIFO memory, zero frees it; software checks config valid.
// - bus reset clears size, banks and reserve on every endpoint except endpoint 0.
// - reserve write one updates config valid: set only if banks and size fit.
// - toggle sequence defaults to 01 so the next packet uses Data0.
package usb_ep_pkg;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [11:0] ENABLE_RESET_OFS = 12'h01c;
    localparam logic [11:0] FRAME_NUMBER_OFS = 12'h020;
    localparam logic [11:0] CONFIG_BASE = 12'h100;
    localparam logic [11:0] STATUS_BASE = 12'h130;
    localparam int MAX_EP = 8;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ENABLE_LSB = 0;
    localparam int SOFT_RESET_LSB = 16;
    localparam int CFG_RESERVE = 1;
    localparam int CFG_BANKS_LSB = 2;
    localparam int CFG_SIZE_LSB = 4;
    localparam int CFG_DIR = 8;
    localparam int CFG_AUTO_BANK_SWITCH = 9;
    localparam int CFG_TYPE_LSB = 11;
    localparam int CFG_TRANS_LSB = 13;
    localparam int ST_COUNT_LSB = 20;
    localparam int ST_CONFIG_VALID = 18;
    localparam int ST_CONTROL_DIRECTION = 17;
    localparam int ST_ACCESS_PERMITTED = 16;
    localparam int ST_BANK_LSB = 14;
    localparam int ST_BUSY_LSB = 12;
    localparam int ST_ERR = 10;
    localparam int ST_TOGGLE_LSB = 8;
    localparam int FR_CRC = 15;
    localparam int FR_NUM_LSB = 3;
    localparam int FR_MICRO_LSB = 0;
    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [31:0] CONFIG_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_RESET = 32'h00000100;
    localparam logic [31:0] FRAME_RESET = 32'h00000000;
    localparam logic [1:0] TOGGLE_DEFAULT = 2'h1;
    localparam logic [1:0] TRANS_RESET = 2'h0;
    localparam logic [1:0] BANKS_RESERVED = 2'h3;
    localparam logic [2:0] SIZE_UNDEFINED = 3'h7;
    localparam logic [15:0] BASE_BANK_BYTES = 16'h0008;
    typedef enum logic [1:0] {XFER_CONTROL, XFER_ISO, XFER_BULK, XFER_INTERRUPT} transfer_e;
endpackage : usb_ep_pkg

// ---- core/usb_frame_tracker.sv ----
/*
 * frame and micro-frame number tracker with the frame CRC error flag.
 * assumes one-cycle strobes from the packet decoder, never both in one cycle.
 */
`timescale 1ns/1ns
module usb_frame_tracker
    import usb_ep_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // packet decoder
    input wire logic busReset,
    input wire logic sofStrobe,
    input wire logic msofStrobe,
    input wire logic [10:0] frameIn,
    input wire logic [2:0] microIn,
    input wire logic pidCrcBad,
    // results
    output logic [31:0] frameWord,
    output logic sofEvent,
    output logic msofEvent
);
    logic crcErr, next_crcErr;
    logic [10:0] frameNum, next_frameNum;
    logic [2:0] microNum, next_microNum;
    logic next_sofEvent, next_msofEvent;

    always_comb begin
        next_crcErr = crcErr;
        next_frameNum = frameNum;
        next_microNum = microNum;
        next_sofEvent = 1'b0;
        next_msofEvent = 1'b0;
        if (busReset) begin
            next_crcErr = 1'b0;
            next_frameNum = 11'h000;
            next_microNum = 3'h0;
        end else if (sofStrobe) begin
            next_crcErr = pidCrcBad;
            next_sofEvent = 1'b1;
            next_frameNum = frameIn;
            next_microNum = 3'h0;
        end else if (msofStrobe) begin
            next_crcErr = pidCrcBad;
            next_msofEvent = 1'b1;
            next_microNum = microIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            crcErr <= 1'b0;
            frameNum <= 11'h000;
            microNum <= 3'h0;
            sofEvent <= 1'b0;
            msofEvent <= 1'b0;
        end else begin
            crcErr <= next_crcErr;
            frameNum <= next_frameNum;
            microNum <= next_microNum;
            sofEvent <= next_sofEvent;
            msofEvent <= next_msofEvent;
        end
    end

    always_comb begin
        frameWord = FRAME_RESET;
        frameWord[FR_CRC] = crcErr;
        frameWord[FR_NUM_LSB +: 11] = frameNum;
        frameWord[FR_MICRO_LSB +: 3] = microNum;
    end
endmodule : usb_frame_tracker

// ---- test/usb_host_model.sv ----
/* usb host side: frame and micro-frame starts and bus reset.
   tasks are entered right after a rising edge of ref_clk. */
`timescale 1ns/1ns
module usb_host_model (
    // clock
    input wire logic ref_clk,
    // towards the packet decoder inputs
    output logic busReset,
    output logic sofStrobe,
    output logic msofStrobe,
    output logic [10:0] frameIn,
    output logic [2:0] microIn,
    output logic pidCrcBad
);
    initial begin
        {busReset, sofStrobe, msofStrobe, pidCrcBad} = 4'h0;
        frameIn = 11'h0;
        microIn = 3'h0;
    end
    // numbers hold only beside their strobe, then turn over
    task automatic pkt(input logic sof, input logic [10:0] f, input logic [2:0] m, input logic bad);
        sofStrobe <= sof;
        msofStrobe <= !sof;
        frameIn <= f;
        microIn <= m;
        pidCrcBad <= bad;
        @(posedge ref_clk);
        {sofStrobe, msofStrobe, pidCrcBad} <= 3'h0;
        frameIn <= ~f;
        microIn <= ~m;
        @(posedge ref_clk);
    endtask : pkt
    task automatic reset_bus();
        busReset <= 1'b1;
        @(posedge ref_clk);
        busReset <= 1'b0;
        @(posedge ref_clk);
    endtask : reset_bus
endmodule : usb_host_model

// ---- test/usb_ep_config_chk.sv ----
/* port assertions for the endpoint management block.
   bound into every usb_ep_config instance. */
`timescale 1ns/1ns
module usb_ep_config_chk #(parameter int NUM_EP = 8) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // watched ports
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic busReset,
    input wire logic sofStrobe,
    input wire logic msofStrobe,
    input wire logic sofEvent,
    input wire logic msofEvent,
    input wire logic [NUM_EP-1:0] epActive,
    input wire logic [NUM_EP-1:0] epFifoReset,
    input wire logic [2*NUM_EP-1:0] epTransferType,
    input wire logic [NUM_EP-1:0] epDirIn,
    input wire logic [NUM_EP-1:0] epAutoSwitch,
    input wire logic [2*NUM_EP-1:0] epBankCount,
    input wire logic [NUM_EP-1:0] epMemReserve,
    input wire logic [2*NUM_EP-1:0] epToggle,
    input wire logic [NUM_EP-1:0] toggleResetReq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence sofSeen; sofStrobe && !busReset; endsequence
    sequence msofSeen; msofStrobe && !busReset; endsequence
    chk_sof_event: assert property (sofSeen |=> sofEvent && !msofEvent)
        else $error("frame event missing");
    chk_msof_event: assert property (msofSeen |=> msofEvent && !sofEvent)
        else $error("micro-frame event missing");
    chk_read_idle: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data outside read slot");
    chk_off_held: assert property ((~epActive & ~epFifoReset) == '0)
        else $error("disabled endpoint fifo running");
    chk_ctrl_dir: assert property (epTransferType[1:0] == 2'h0 |-> !epDirIn[0])
        else $error("control endpoint shown as in");
    chk_bus_clear: assert property (busReset |=> epTransferType == '0 && epDirIn == '0 && epAutoSwitch == '0)
        else $error("bus reset left type, direction or switch");
    chk_bus_keep0: assert property (busReset |=> epBankCount[2*NUM_EP-1:2] == '0 && epMemReserve[NUM_EP-1:1] == '0)
        else $error("bus reset left banks or reserve");
    chk_toggle_req: assert property (toggleResetReq[1] |=> epToggle[3:2] == 2'h1)
        else $error("toggle not restored");
endmodule : usb_ep_config_chk
bind usb_ep_config usb_ep_config_chk #(.NUM_EP(NUM_EP)) chkU (.*);

// ---- test/testbench.sv ----
/* self-checking bench for usb_ep_config with a usb host model.
   expects the checker bound through its own file. */
`timescale 1ns/1ns
module testbench
    import usb_ep_pkg::*;
;
    logic ref_clk, rst_b, regWrite, regRead, rdPend = 1'b0;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata, c, expQ[$];
    logic busReset, sofStrobe, msofStrobe, pidCrcBad, sofEvent, msofEvent;
    logic [10:0] frameIn, f;
    logic [2:0] microIn;
    logic [7:0] epActive, epFifoReset, epDirIn, epAutoSwitch, epMemReserve, epConfigValid;
    logic [7:0] fifoCtrlDir, fifoRwAll, fifoTransErr, toggleLoad, toggleResetReq;
    logic [15:0] epTransferType, epBankCount, epTransactions, epToggle, fifoCurBank, fifoBusyBanks, toggleIn;
    logic [23:0] epBankSize;
    logic [87:0] fifoByteCount;
    logic [63:0] fifoEvents;
    logic [31:0] bad[2] = '{32'hc, 32'h70};
    int mismatches = 0, compares = 0;
    usb_ep_config #(.HB_ISO_CAPABLE(8'hfb)) dut_u (.*);
    usb_host_model hostU (.*);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    always @(posedge ref_clk) begin
        if (rdPend)
            check("regRdata", regRdata, expQ.pop_front());
        rdPend <= regRead;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {rst_b, regWrite, regRead, toggleLoad, toggleResetReq, toggleIn} = '0;
        regAddr = 12'h0;
        regWdata = 32'h0;
        void'($urandom(32'h77fdfa3a));
        fifoByteCount = 88'({$urandom, $urandom, $urandom});
        {fifoCtrlDir, fifoRwAll, fifoTransErr} = 24'($urandom);
        {fifoCurBank, fifoBusyBanks} = $urandom;
        fifoEvents = {$urandom, $urandom};
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd(FRAME_NUMBER_OFS, FRAME_RESET);
        rd(CONFIG_BASE, CONFIG_RESET);
        rd(STATUS_BASE, STATUS_RESET);
        rd(12'hff0, 32'h0);
        $display("test done: reset values");
        f = 11'($urandom);
        hostU.pkt(1'b1, f, 3'h5, 1'b1);
        rd(FRAME_NUMBER_OFS, {16'h0, 2'h2, f, 3'h0});
        hostU.pkt(1'b0, ~f, 3'h6, 1'b1);
        rd(FRAME_NUMBER_OFS, {16'h0, 2'h2, f, 3'h6});
        hostU.pkt(1'b1, ~f, 3'h2, 1'b0);
        rd(FRAME_NUMBER_OFS, {16'h0, 2'h0, ~f, 3'h0});
        hostU.reset_bus();
        rd(FRAME_NUMBER_OFS, 32'h0);
        $display("test done: frame numbers");
        wr(ENABLE_RESET_OFS, 32'h7);
        check("epActive", epActive, 8'h7);
        wr(CONFIG_BASE + 12'h8, 32'h2000);
        rd(CONFIG_BASE + 12'h8, 32'h0);
        for (int t = 0; t < 4; t++) begin
            c = {17'h0, 2'h2, 2'(t), 3'h3, 4'h3, 2'(t != 0), 2'h2};
            wr(CONFIG_BASE + 12'h4, c);
            rd(CONFIG_BASE + 12'h4, c);
            check("epDirIn", epDirIn[1], t != 0);
            check("epTransferType", epTransferType[3:2], t);
            check("epConfigValid", epConfigValid[1], 1);
            check("epBankSize", epBankSize[5:3], 3'h3);
            check("epTransactions", epTransactions[3:2], 2'h2);
        end
        foreach (bad[i]) begin
            wr(CONFIG_BASE + 12'h4, c | bad[i]);
            check("epConfigValid", epConfigValid[1], 0);
        end
        wr(CONFIG_BASE + 12'h4, c);
        rd(STATUS_BASE + 12'h4, {1'b0, fifoByteCount[21:11], 2'h1, fifoCtrlDir[1], fifoRwAll[1], fifoCurBank[3:2],
            fifoBusyBanks[3:2], 1'b0, fifoTransErr[1], 2'h1, fifoEvents[15:8]});
        $display("test done: configuration");
        toggleIn[3:2] <= 2'h2;
        toggleLoad[1] <= 1'b1;
        @(posedge ref_clk);
        toggleLoad[1] <= 1'b0;
        wr(ENABLE_RESET_OFS, 32'h20007);
        check("epFifoReset", epFifoReset[1], 1);
        check("epActive", epActive[1], 1);
        check("epToggle", epToggle[3:2], 2'h2);
        rd(CONFIG_BASE + 12'h4, c & ~32'h6200);
        toggleResetReq[1] <= 1'b1;
        @(posedge ref_clk);
        toggleResetReq[1] <= 1'b0;
        wr(ENABLE_RESET_OFS, 32'h7);
        check("epToggle", epToggle[3:2], 2'h1);
        check("epFifoReset", epFifoReset[1], 0);
        wr(ENABLE_RESET_OFS, 32'h5);
        check("epFifoReset", epFifoReset[1], 1);
        rd(CONFIG_BASE + 12'h4, c & ~32'h6200);
        $display("test done: endpoint reset");
        wr(CONFIG_BASE, 32'h232);
        wr(CONFIG_BASE + 12'h4, c & ~32'h6000);
        wr(ENABLE_RESET_OFS, 32'h20007);
        hostU.reset_bus();
        rd(CONFIG_BASE, 32'h32);
        rd(CONFIG_BASE + 12'h4, 32'h0);
        rd(ENABLE_RESET_OFS, 32'h7);
        $display("test done: bus reset");
        @(posedge ref_clk);
        stop_test();
    end
endmodule : testbench
